// file: verilog/extint_top.sv
// External interrupt detector with AXI4-Lite register access
`timescale 1ns/1ps
`include "extint_regs.svh"

// Contract
// - Code 10 rising edge, 11 falling edge, channels 0-15 only
// - Channels 0-15 wake from stop, any code; the logic wakes only on unmasked pending channels
// - Unmasked channel condition requests the controller
// - Clear and unmask accepted in one write
// - Edges need three cycles of hold
// - Levels need three cycles of hold
// - Held level re-requests after pending cleared
// - Latched level request stays until cleared
// - Code 00 low level, 01 high level
// - Unmask forwards; masked still latches pending
// - Write zero clears pending, one ignored
module extint_top (
	input  wire logic                     clk_i,
	input  wire logic                     resetn_i,
	// Request pins and stop mode
	input  wire logic [`EXTINT_NCH-1:0]   req_pin_i,
	input  wire logic                     stop_i,
	output logic      [`EXTINT_NCH-1:0]   irq_req_o,
	output logic                          wake_o,
	output logic                          irq_o,
	// AXI4-Lite write address
	input  wire logic                     axi_awvalid_i,
	output logic                          axi_awready_o,
	input  wire logic [`EXTINT_ADDR_W-1:0] axi_awaddr_i,
	input  wire logic [2:0]               axi_awprot_i,
	// AXI4-Lite write data
	input  wire logic                     axi_wvalid_i,
	output logic                          axi_wready_o,
	input  wire logic [31:0]              axi_wdata_i,
	input  wire logic [3:0]               axi_wstrb_i,
	// AXI4-Lite write response
	output logic                          axi_bvalid_o,
	input  wire logic                     axi_bready_i,
	output logic      [1:0]               axi_bresp_o,
	// AXI4-Lite read address
	input  wire logic                     axi_arvalid_i,
	output logic                          axi_arready_o,
	input  wire logic [`EXTINT_ADDR_W-1:0] axi_araddr_i,
	input  wire logic [2:0]               axi_arprot_i,
	// AXI4-Lite read data
	output logic                          axi_rvalid_o,
	input  wire logic                     axi_rready_i,
	output logic      [31:0]              axi_rdata_o,
	output logic      [1:0]               axi_rresp_o
);

	localparam logic [`EXTINT_ADDR_W-1:0] BANK_ADDR [`EXTINT_NBANK] = '{
		`EXTINT_BANK0_ADDR, `EXTINT_BANK1_ADDR, `EXTINT_BANK2_ADDR
	};

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [2*`EXTINT_NCH-1:0]             sense_r;
	logic [`EXTINT_NCH-1:0]               unmask_r;
	logic [`EXTINT_NCH-1:0]               pend;
	logic [`EXTINT_NCH-1:0]               det;
	logic [`EXTINT_NCH-1:0]               clr;
	logic [`EXTINT_NCH-1:0]               evt_stat_r;
	logic [`EXTINT_NCH-1:0]               evt_mask_r;
	logic                                 wake_r;

	extint_pkg::extint_wr_state_e         wr_state_r;
	logic                                 aw_have_r;
	logic                                 w_have_r;
	logic [`EXTINT_ADDR_W-1:0]            waddr_r;
	logic [31:0]                          wdata_r;
	logic [3:0]                           wstrb_r;
	logic [1:0]                           bresp_r;
	logic                                 rvalid_r;
	logic [31:0]                          rdata_r;
	logic [1:0]                           rresp_r;

	logic                                 do_wr;
	logic [`EXTINT_NBANK-1:0]             wr_bank;
	logic                                 wr_evt_st;
	logic                                 wr_evt_mk;
	logic                                 wr_hit;
	logic [31:0]                          rd_word;
	logic                                 rd_hit;

	// ------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------
	// Upper channels keep only the level codes, so edge hardware is left out there
	genvar gc;
	generate
		for (gc = 0; gc < `EXTINT_NCH; gc++) begin : g_ch
			extint_chan #(
				.EDGE_EN (gc < `EXTINT_EDGE_CH)
			) u_chan (
				.clk_i    (clk_i),
				.resetn_i (resetn_i),
				.pin_i    (req_pin_i[gc]),
				.sense_i  (extint_pkg::extint_sense_e'(sense_r[2*gc+1 -: 2])),
				.clr_i    (clr[gc]),
				.det_o    (det[gc]),
				.pend_o   (pend[gc])
			);
		end
	endgenerate

	// Masked channels still latch; only the forward path is gated
	assign irq_req_o = pend & unmask_r;

	// ------------------------------------------------------------
	// Stop-mode wake
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			wake_r <= 1'b0;
		end else begin
			wake_r <= stop_i && (|irq_req_o[`EXTINT_WAKE_CH-1:0]);
		end
	end

	assign wake_o = wake_r;

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	assign axi_awready_o = (wr_state_r == extint_pkg::EXTINT_WR_COLLECT) && !aw_have_r;
	assign axi_wready_o  = (wr_state_r == extint_pkg::EXTINT_WR_COLLECT) && !w_have_r;
	assign do_wr         = (wr_state_r == extint_pkg::EXTINT_WR_COLLECT) && aw_have_r && w_have_r;
	assign axi_bvalid_o  = (wr_state_r == extint_pkg::EXTINT_WR_RESP);
	assign axi_bresp_o   = bresp_r;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			aw_have_r <= 1'b0;
			waddr_r   <= '0;
		end else if (axi_awvalid_i && axi_awready_o) begin
			aw_have_r <= 1'b1;
			waddr_r   <= axi_awaddr_i;
		end else if (do_wr) begin
			aw_have_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			w_have_r <= 1'b0;
			wdata_r  <= '0;
			wstrb_r  <= '0;
		end else if (axi_wvalid_i && axi_wready_o) begin
			w_have_r <= 1'b1;
			wdata_r  <= axi_wdata_i;
			wstrb_r  <= axi_wstrb_i;
		end else if (do_wr) begin
			w_have_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			wr_state_r <= extint_pkg::EXTINT_WR_COLLECT;
			bresp_r    <= `EXTINT_RESP_OKAY;
		end else begin
			case (wr_state_r)
				extint_pkg::EXTINT_WR_COLLECT: begin
					if (do_wr) begin
						wr_state_r <= extint_pkg::EXTINT_WR_RESP;
						bresp_r    <= wr_hit ? `EXTINT_RESP_OKAY : `EXTINT_RESP_SLVERR;
					end
				end
				extint_pkg::EXTINT_WR_RESP: begin
					if (axi_bready_i) begin
						wr_state_r <= extint_pkg::EXTINT_WR_COLLECT;
					end
				end
				default: wr_state_r <= extint_pkg::EXTINT_WR_COLLECT;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	always_comb begin
		for (int b = 0; b < `EXTINT_NBANK; b++) begin
			wr_bank[b] = do_wr && (waddr_r == BANK_ADDR[b]);
		end
	end

	assign wr_evt_st = do_wr && (waddr_r == `EXTINT_EVT_ST_ADDR);
	assign wr_evt_mk = do_wr && (waddr_r == `EXTINT_EVT_MK_ADDR);
	assign wr_hit    = (|wr_bank) || wr_evt_st || wr_evt_mk;

	// Top byte clears pending on zeros; the same write may also unmask through byte lane 2
	always_comb begin
		for (int c = 0; c < `EXTINT_NCH; c++) begin
			clr[c] = wr_bank[c/`EXTINT_BANK_CH] && wstrb_r[3]
				&& !wdata_r[`EXTINT_PEND_LSB + (c % `EXTINT_BANK_CH)];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			unmask_r <= `EXTINT_MASK_RST;
		end else begin
			for (int b = 0; b < `EXTINT_NBANK; b++) begin
				if (wr_bank[b] && wstrb_r[2]) begin
					unmask_r[b*`EXTINT_BANK_CH +: `EXTINT_BANK_CH]
						<= wdata_r[`EXTINT_MASK_LSB +: `EXTINT_BANK_CH];
				end
			end
		end
	end

	// A sense change may fake a detection; the pending flag then wants a clear
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			sense_r <= `EXTINT_SENSE_RST;
		end else begin
			for (int b = 0; b < `EXTINT_NBANK; b++) begin
				if (wr_bank[b] && wstrb_r[0]) begin
					sense_r[b*16 +: 8] <= wdata_r[`EXTINT_SENSE_LSB +: 8];
				end
				if (wr_bank[b] && wstrb_r[1]) begin
					sense_r[b*16+8 +: 8] <= wdata_r[`EXTINT_SENSE_LSB+8 +: 8];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Event status, mask and interrupt line
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			evt_stat_r <= '0;
		end else if (wr_evt_st) begin
			// A detection in the clearing cycle survives
			evt_stat_r <= (evt_stat_r & ~wdata_r[`EXTINT_NCH-1:0]) | det;
		end else begin
			evt_stat_r <= evt_stat_r | det;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			evt_mask_r <= '0;
		end else if (wr_evt_mk) begin
			evt_mask_r <= wdata_r[`EXTINT_NCH-1:0];
		end
	end

	assign irq_o = |(evt_stat_r & evt_mask_r);

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	always_comb begin
		rd_word = '0;
		rd_hit  = 1'b0;
		for (int b = 0; b < `EXTINT_NBANK; b++) begin
			if (axi_araddr_i == BANK_ADDR[b]) begin
				rd_hit  = 1'b1;
				rd_word = {pend[b*`EXTINT_BANK_CH +: `EXTINT_BANK_CH],
					unmask_r[b*`EXTINT_BANK_CH +: `EXTINT_BANK_CH],
					sense_r[b*16 +: 16]};
			end
		end
		if (axi_araddr_i == `EXTINT_EVT_ST_ADDR) begin
			rd_hit  = 1'b1;
			rd_word = {8'h00, evt_stat_r};
		end
		if (axi_araddr_i == `EXTINT_EVT_MK_ADDR) begin
			rd_hit  = 1'b1;
			rd_word = {8'h00, evt_mask_r};
		end
	end

	assign axi_arready_o = !rvalid_r;
	assign axi_rvalid_o  = rvalid_r;
	assign axi_rdata_o   = rdata_r;
	assign axi_rresp_o   = rresp_r;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= `EXTINT_RESP_OKAY;
		end else if (axi_arvalid_i && axi_arready_o) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_word;
			rresp_r  <= rd_hit ? `EXTINT_RESP_OKAY : `EXTINT_RESP_SLVERR;
		end else if (axi_rready_i) begin
			rvalid_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_WAKE: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(stop_i && (|(pend[`EXTINT_WAKE_CH-1:0] & unmask_r[`EXTINT_WAKE_CH-1:0]))) |=> wake_o)
		else $error("unmasked low channel did not wake");

	AST_COMBINED: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(wr_bank[0] && wstrb_r[3] && wstrb_r[2] && !wdata_r[`EXTINT_PEND_LSB] && !det[0])
		|=> (unmask_r[0] == $past(wdata_r[`EXTINT_MASK_LSB])) && !pend[0])
		else $error("combined clear and unmask not applied");

	AST_FORWARD: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(det[0] && unmask_r[0] && !wr_bank[0]) |=> irq_req_o[0])
		else $error("unmasked detection not forwarded");

	AST_MASKED: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(det[1] && !unmask_r[1] && !wr_bank[0]) |=> pend[1] && !irq_req_o[1])
		else $error("masked channel forwarded or failed to latch");

	AST_BRESP: assert property (@(posedge clk_i) disable iff (!resetn_i)
		do_wr |=> axi_bvalid_o)
		else $error("write response missing");

endmodule

// file: verilog/extint_regs.svh
// Register offsets, field positions, reset values and timing counts of the external interrupt detector
`ifndef EXTINT_REGS_SVH
`define EXTINT_REGS_SVH

// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define EXTINT_NCH          24
`define EXTINT_NBANK        3
`define EXTINT_BANK_CH      8
`define EXTINT_WAKE_CH      16
`define EXTINT_EDGE_CH      16
`define EXTINT_ADDR_W       12

// ------------------------------------------------------------
// Offsets (byte addresses)
// ------------------------------------------------------------
`define EXTINT_BANK0_ADDR   12'h040
`define EXTINT_BANK1_ADDR   12'h0C0
`define EXTINT_BANK2_ADDR   12'h0C4
`define EXTINT_EVT_ST_ADDR  12'h100
`define EXTINT_EVT_MK_ADDR  12'h104

// ------------------------------------------------------------
// Fields of a bank word
// ------------------------------------------------------------
`define EXTINT_PEND_LSB     24
`define EXTINT_MASK_LSB     16
`define EXTINT_SENSE_LSB    0

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define EXTINT_SENSE_RST    48'h000000000000
`define EXTINT_MASK_RST     24'h000000
`define EXTINT_MIN_HOLD_CYC 3
`define EXTINT_RESP_OKAY    2'h0
`define EXTINT_RESP_SLVERR  2'h2

`endif

// file: verilog/extint_pkg.sv
// Types shared by the external interrupt detector
package extint_pkg;

	// Sense code order matches the two-bit codes 00, 01, 10, 11
	typedef enum logic [1:0] {
		EXTINT_SENSE_LOW,
		EXTINT_SENSE_HIGH,
		EXTINT_SENSE_RISE,
		EXTINT_SENSE_FALL
	} extint_sense_e;

	typedef enum logic {
		EXTINT_WR_COLLECT,
		EXTINT_WR_RESP
	} extint_wr_state_e;

endpackage

// file: verilog/extint_chan.sv
// One request channel: synchroniser, width filter, sense decode and pending flag
`timescale 1ns/1ps
`include "extint_regs.svh"

module extint_chan #(
	parameter bit EDGE_EN = 1'b1
) (
	input  wire logic                      clk_i,
	input  wire logic                      resetn_i,
	input  wire logic                      pin_i,
	input  wire extint_pkg::extint_sense_e sense_i,
	input  wire logic                      clr_i,
	output logic                           det_o,
	output logic                           pend_o
);

	logic                                  sync1_r;
	logic                                  sync2_r;
	logic [`EXTINT_MIN_HOLD_CYC-1:0]       hist_r;
	logic                                  filt_r;
	logic                                  filt_d_r;
	logic                                  pend_r;

	// ------------------------------------------------------------
	// Synchroniser and width filter
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
		end else begin
			sync1_r <= pin_i;
			sync2_r <= sync1_r;
		end
	end

	// Idle high so a pulled-up pin does not fake a low-level request at reset
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			hist_r   <= '1;
			filt_r   <= 1'b1;
			filt_d_r <= 1'b1;
		end else begin
			hist_r   <= {hist_r[`EXTINT_MIN_HOLD_CYC-2:0], sync2_r};
			filt_d_r <= filt_r;
			if (&hist_r) begin
				filt_r <= 1'b1;
			end else if (~|hist_r) begin
				filt_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Sense decode
	// ------------------------------------------------------------
	always_comb begin
		case (sense_i)
			extint_pkg::EXTINT_SENSE_LOW:  det_o = !filt_r;
			extint_pkg::EXTINT_SENSE_HIGH: det_o = filt_r;
			extint_pkg::EXTINT_SENSE_RISE: det_o = EDGE_EN && filt_r && !filt_d_r;
			extint_pkg::EXTINT_SENSE_FALL: det_o = EDGE_EN && !filt_r && filt_d_r;
			default:                       det_o = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Pending flag: a detection wins over a clear in the same cycle
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pend_r <= 1'b0;
		end else if (det_o) begin
			pend_r <= 1'b1;
		end else if (clr_i) begin
			pend_r <= 1'b0;
		end
	end

	assign pend_o = pend_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_FILT_AGREE: assert property (@(posedge clk_i) disable iff (!resetn_i)
		$changed(filt_r) |-> $past(hist_r) == {`EXTINT_MIN_HOLD_CYC{filt_r}})
		else $error("filtered level moved without agreeing samples");

	AST_LOW_HELD: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(!sync2_r)[*3] |=> ##1 !filt_r)
		else $error("three low samples did not reach the filter");

	AST_HIGH_HELD: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(sync2_r)[*3] |=> ##1 filt_r)
		else $error("three high samples did not reach the filter");

	AST_RISE_SET: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(EDGE_EN && sense_i == extint_pkg::EXTINT_SENSE_RISE && $rose(filt_r)) |=> pend_r)
		else $error("rising edge not latched");

	AST_FALL_SET: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(EDGE_EN && sense_i == extint_pkg::EXTINT_SENSE_FALL && $fell(filt_r)) |=> pend_r)
		else $error("falling edge not latched");

	AST_LEVEL_SET: assert property (@(posedge clk_i) disable iff (!resetn_i)
		((sense_i == extint_pkg::EXTINT_SENSE_LOW && !filt_r)
		|| (sense_i == extint_pkg::EXTINT_SENSE_HIGH && filt_r)) |=> pend_r)
		else $error("active level not latched");

	AST_HOLD_CLR: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(clr_i && sense_i == extint_pkg::EXTINT_SENSE_LOW && !filt_r) |=> pend_r)
		else $error("held level lost on clear");

	AST_LATCH: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(pend_r && !clr_i) |=> pend_r)
		else $error("pending flag dropped without a clear");

	AST_CLEAR: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(pend_r && clr_i && !det_o) |=> !pend_r)
		else $error("clear did not drop the pending flag");

	AST_NO_EDGE: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(!EDGE_EN && sense_i[1]) |-> !det_o)
		else $error("edge code detected on a level-only channel");

endmodule

// file: verification/extint_src_model.sv
// Behavioural model of the external sources that drive the request pins
`timescale 1ns/1ps

module extint_src_model (
	input  wire logic        clk_i,
	output logic      [23:0] pin_o
);
	// Pins rest high so the reset sense code sees no request
	initial pin_o = 24'hFFFFFF;

	task automatic set_lvl(input int ch, input logic v);
		@(posedge clk_i);
		pin_o[ch] <= v;
	endtask

	// Pulses shorter than the minimum hold are stretched, never sent short
	task automatic pulse(input int ch, input int len);
		int h;
		h = (len < 3) ? 3 : len;
		@(posedge clk_i);
		pin_o[ch] <= ~pin_o[ch];
		repeat (h) @(posedge clk_i);
		pin_o[ch] <= ~pin_o[ch];
	endtask
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the external interrupt detector
`timescale 1ns/1ps
`include "extint_regs.svh"

module tb_top;
	logic        clk_i = 1'b0, resetn_i = 1'b0, stop_i = 1'b0, lvl;
	logic [23:0] pins, irq_req, msk = 0, pnd = 0, evs = 0, evm = 0;
	logic        wake, irq, awv = 0, awr, wv = 0, wrdy, bv, arv = 0, arr, rv;
	logic [11:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd_d, rdv;
	logic [3:0]  ws = 0;
	logic [1:0]  bresp, rresp, rsv, sns [24];
	int          n_fail = 0, checked = 0, ch, r;

	always #2.5 clk_i = ~clk_i;

	extint_src_model u_src (.clk_i(clk_i), .pin_o(pins));

	extint_top u_dut (
		.clk_i(clk_i), .resetn_i(resetn_i), .req_pin_i(pins), .stop_i(stop_i),
		.irq_req_o(irq_req), .wake_o(wake), .irq_o(irq),
		.axi_awvalid_i(awv), .axi_awready_o(awr), .axi_awaddr_i(awa), .axi_awprot_i(3'h0),
		.axi_wvalid_i(wv), .axi_wready_o(wrdy), .axi_wdata_i(wd), .axi_wstrb_i(ws),
		.axi_bvalid_o(bv), .axi_bready_i(1'b1), .axi_bresp_o(bresp),
		.axi_arvalid_i(arv), .axi_arready_o(arr), .axi_araddr_i(ara), .axi_arprot_i(3'h0),
		.axi_rvalid_o(rv), .axi_rready_i(1'b1), .axi_rdata_o(rd_d), .axi_rresp_o(rresp)
	);

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic end_sim();
		$display("checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task automatic tmo();
		n_fail++;
		$display("CHECK FAILED at %0t: bus answer never came", $time);
		end_sim();
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Ready is sampled at the falling edge; inputs only move after rising edges
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] er);
		logic ga, gw, gb;
		gb = 1'b0;
		awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; ws <= s;
		for (int n = 0; n < 50 && !gb; n++) begin
			@(negedge clk_i);
			ga = awv & awr;
			gw = wv & wrdy;
			gb = bv;
			if (gb) chk({30'h0, bresp}, {30'h0, er}, "write response");
			@(posedge clk_i);
			if (ga) awv <= 1'b0;
			if (gw) wv <= 1'b0;
		end
		if (!gb) tmo();
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
		logic ga, got;
		got = 1'b0;
		arv <= 1'b1; ara <= a;
		for (int n = 0; n < 50 && !got; n++) begin
			@(negedge clk_i);
			ga = arv & arr;
			got = rv;
			d = rd_d;
			rs = rresp;
			@(posedge clk_i);
			if (ga) arv <= 1'b0;
		end
		if (!got) tmo();
	endtask

	function automatic logic [11:0] baddr(input int c);
		return (c < 8) ? `EXTINT_BANK0_ADDR : (c < 16) ? `EXTINT_BANK1_ADDR : `EXTINT_BANK2_ADDR;
	endfunction

	function automatic logic [31:0] exp_word(input logic [11:0] a);
		int b;
		logic [15:0] s;
		b = (a == `EXTINT_BANK0_ADDR) ? 0 : (a == `EXTINT_BANK1_ADDR) ? 1 : 2;
		for (int k = 0; k < 8; k++) s[2*k+:2] = sns[8*b+k];
		if (a == `EXTINT_EVT_ST_ADDR) return {8'h00, evs};
		if (a == `EXTINT_EVT_MK_ADDR) return {8'h00, evm};
		return {pnd[8*b+:8], msk[8*b+:8], s};
	endfunction

	task automatic rd_chk(input logic [11:0] a);
		logic [31:0] d;
		logic [1:0] rs;
		rd(a, d, rs);
		chk(d, exp_word(a), "register read");
		chk({30'h0, rs}, {30'h0, `EXTINT_RESP_OKAY}, "read response");
	endtask

	// Bank write built from the model, with the pending byte given apart
	task automatic wrb(input int c, input logic [3:0] s, input logic [7:0] pb);
		logic [31:0] d;
		d = exp_word(baddr(c));
		d[31:24] = pb;
		wr(baddr(c), d, s, `EXTINT_RESP_OKAY);
	endtask

	// Look off the launching edge so the registered wake line has settled
	task automatic chk_out();
		@(negedge clk_i);
		chk({6'h0, irq_req, wake, irq},
			{6'h0, msk & pnd, stop_i & |(msk[15:0] & pnd[15:0]), |(evs & evm)}, "outputs");
		@(posedge clk_i);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		r = $urandom(69);
		foreach (sns[i]) sns[i] = 2'h0;
		cyc(10);
		resetn_i <= 1'b1;
		cyc(10);
		rd_chk(`EXTINT_BANK0_ADDR);
		rd_chk(`EXTINT_BANK1_ADDR);
		rd_chk(`EXTINT_BANK2_ADDR);
		rd_chk(`EXTINT_EVT_ST_ADDR);
		rd_chk(`EXTINT_EVT_MK_ADDR);
		rd(12'h200, rdv, rsv);
		chk(rdv, 32'h0, "unmapped read data");
		chk({30'h0, rsv}, {30'h0, `EXTINT_RESP_SLVERR}, "unmapped read");
		wr(12'h200, 32'hFFFFFFFF, 4'hF, `EXTINT_RESP_SLVERR);
		rd_chk(`EXTINT_BANK0_ADDR);
		chk_out();
		$display("test reset done");
		stop_i <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			// One channel per code group, so no channel inherits an earlier setup
			ch = 4 * c + $urandom_range(3, 0);
			lvl = ~(c[0] ^ c[1]);
			u_src.set_lvl(ch, lvl);
			cyc(10);
			// An idle low level under the reset code already latches a request
			pnd[ch] = ~lvl;
			msk[ch] = 1'b0;
			wrb(ch, 4'h4, 8'hFF);
			sns[ch] = c[1:0];
			wrb(ch, 4'h3, 8'hFF);
			rd_chk(baddr(ch));
			pnd[ch] = 1'b0;
			msk[ch] = 1'b1;
			wrb(ch, 4'hC, ~(8'h01 << (ch % 8)));
			wr(`EXTINT_EVT_ST_ADDR, 32'h00FFFFFF, 4'hF, `EXTINT_RESP_OKAY);
			evs = 24'h0;
			cyc(2);
			chk_out();
			u_src.pulse(ch, $urandom_range(6, 3));
			cyc(14);
			pnd[ch] = 1'b1;
			evs[ch] = 1'b1;
			rd_chk(baddr(ch));
			chk_out();
			if (c < 2) begin
				u_src.set_lvl(ch, ~lvl);
				cyc(10);
				wrb(ch, 4'h8, ~(8'h01 << (ch % 8)));
				cyc(10);
				rd_chk(baddr(ch));
				chk_out();
				stop_i <= 1'b0;
				cyc(2);
				chk_out();
				stop_i <= 1'b1;
				u_src.set_lvl(ch, lvl);
				cyc(10);
			end
			pnd[ch] = 1'b0;
			msk[ch] = 1'b0;
			wrb(ch, 4'hC, ~(8'h01 << (ch % 8)));
			chk_out();
			$display("test sense code %0d on channel %0d done", c, ch);
		end
		ch = 16 + $urandom_range(7, 0);
		u_src.pulse(ch, 3);
		cyc(14);
		pnd[ch] = 1'b1;
		evs[ch] = 1'b1;
		wrb(ch, 4'h8, 8'hFF);
		rd_chk(baddr(ch));
		rd_chk(`EXTINT_EVT_ST_ADDR);
		chk_out();
		evm[ch] = 1'b1;
		wr(`EXTINT_EVT_MK_ADDR, {8'h00, evm}, 4'hF, `EXTINT_RESP_OKAY);
		cyc(2);
		rd_chk(`EXTINT_EVT_MK_ADDR);
		chk_out();
		evs[ch] = 1'b0;
		wr(`EXTINT_EVT_ST_ADDR, {8'h00, 24'h000001 << ch}, 4'hF, `EXTINT_RESP_OKAY);
		cyc(2);
		rd_chk(`EXTINT_EVT_ST_ADDR);
		chk_out();
		pnd[ch] = 1'b0;
		wrb(ch, 4'h8, ~(8'h01 << (ch % 8)));
		rd_chk(baddr(ch));
		$display("test masked channel and event interrupt done");
		end_sim();
	end
endmodule
